// *** include/rbm_defines.svh ***
// Timing counts and sizes shared by the repeater bus frame monitor.
`ifndef RBM_DEFINES_SVH
`define RBM_DEFINES_SVH

`define RBM_CLK_PERIOD_NS 50
`define RBM_SETTLE_NS 200
`define RBM_SETTLE_CYCLES ((`RBM_SETTLE_NS + `RBM_CLK_PERIOD_NS - 1) / `RBM_CLK_PERIOD_NS)
`define RBM_FIFO_DEPTH 8
`define RBM_NIBBLE_W 4

`endif

// *** include/rbm_pkg.sv ***
// Types shared by the repeater bus frame monitor.
package rbm_pkg;

   typedef enum logic [3:0]
   {
      ST_IDLE   = 4'h1,
      ST_FRAME  = 4'h2,
      ST_SETTLE = 4'h4,
      ST_COMMIT = 4'h8
   } rbm_state_t;

   typedef struct packed
   {
      logic       frameActive;
      logic       transmitSymbolError;
      logic       sharedCollision_n;
      logic       busDataValid_n;
      logic [3:0] txNibble;
   } rbm_bus_t;

   typedef struct packed
   {
      logic [3:0] controllerIndex;
      logic [3:0] portNumber;
   } rbm_id_t;

   typedef struct packed
   {
      rbm_id_t     source;
      logic        sourceValid;
      logic        symbolError;
      logic        falseCarrier;
      logic        rateMismatch;
      logic [7:0]  collisions;
      logic [15:0] nibbles;
      logic [3:0]  nibbleXor;
   } rbm_stat_t;

endpackage

// *** rtl/rbm_frame_monitor.sv ***
// Repeater bus frame monitor: frames packets and commits one statistics record per frame started from idle.
`timescale 1ns/1ns
`include "rbm_defines.svh"


module rbm_fifo
   #(
      parameter int WIDTH = 40,
      parameter int DEPTH = `RBM_FIFO_DEPTH
   )
   (
      input  wire logic             clk,
      input  wire logic             rst,
      input  wire logic [WIDTH-1:0] inData,
      input  wire logic             inValid,
      output logic                  inReady,
      output logic      [WIDTH-1:0] outData,
      output logic                  outValid,
      input  wire logic             outReady
   );

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int PW = AW + 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_badDepth
      $error("FIFO depth must be a power of two of at least two.");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_r;
   logic [PW-1:0]    rdPtr_r;
   logic [WIDTH-1:0] outData_r;
   logic             outValid_r;

   wire empty = (wrPtr_r == rdPtr_r);
   wire full  = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
   wire push  = inValid && !full;
   wire pop   = !empty && (!outValid_r || outReady);

   assign inReady  = !full;
   assign outData  = outData_r;
   assign outValid = outValid_r;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr_r[AW-1:0]] <= inData;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end
      else
      begin
         wrPtr_r <= wrPtr_r + PW'(push);
         rdPtr_r <= rdPtr_r + PW'(pop);
      end
   end

   // The output stage is a register so the consumer sees flop outputs.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         outValid_r <= 1'b0;
         outData_r  <= '0;
      end
      else if (pop)
      begin
         outValid_r <= 1'b1;
         outData_r  <= mem[rdPtr_r[AW-1:0]];
      end
      else if (outReady)
         outValid_r <= 1'b0;
   end

endmodule

module rbm_frame_monitor
   import rbm_pkg::*;
   #(
      parameter int FIFO_DEPTH    = `RBM_FIFO_DEPTH,
      parameter int SETTLE_CYCLES = `RBM_SETTLE_CYCLES
   )
   (
      input  wire logic       clk,
      input  wire logic       rst,
      input  wire logic       mgmtClock,
      input  wire logic [3:0] txNibble,
      input  wire logic       frameActive,
      input  wire logic       transmitSymbolError,
      input  wire logic       sharedCollision_n,
      input  wire logic       busDataValid_n,
      input  wire logic [3:0] mgmtNibble,
      input  wire logic       mgmtValid_n,
      input  wire logic       rateMismatchError_n,
      input  wire logic       statReady,
      output logic            statValid,
      output rbm_stat_t       statRecord,
      input  wire logic       overrunClear,
      output logic            overrun
   );

   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
   begin : g_badSettle
      $error("Settle cycles must lie between 1 and 255.");
   end

   // Local clock domain: pin synchronisers, state, settle counter and overrun flag.
   rbm_bus_t   busS1_r;
   rbm_bus_t   busS2_r;
   logic       framePrev_r;
   rbm_state_t state_r;
   rbm_state_t state_nxt;
   logic [7:0] settleCnt_r;
   logic       overrun_r;

   // Per-frame accumulators.
   logic        symbolError_r;
   logic        falseCarrier_r;
   logic        colPrev_r;
   logic [7:0]  collisions_r;
   logic [15:0] nibbles_r;
   logic [3:0]  nibbleXor_r;
   rbm_id_t     idLocal_r;
   logic        idValid_r;
   logic        frameTog_r;

   // Crossing from the management domain.
   logic        idTogS1_r;
   logic        idTogS2_r;
   logic        idTogS3_r;
   logic        mismatchS1_r;
   logic        mismatchS2_r;

   // Management clock domain.
   logic        mRstS1_r;
   logic        mRst_r;
   logic        fmS1_r;
   logic        fmS2_r;
   logic        fmPrev_r;
   logic        tgS1_r;
   logic        tgS2_r;
   logic        nibPhase_r;
   logic        idDone_r;
   logic        idTog_r;
   logic        mismatch_r;
   rbm_id_t     idMgmt_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busS1_r     <= '0;
         busS2_r     <= '0;
         framePrev_r <= 1'b0;
      end
      else
      begin
         busS1_r     <= '{frameActive, transmitSymbolError, sharedCollision_n,
                          busDataValid_n, txNibble};
         busS2_r     <= busS1_r;
         framePrev_r <= busS2_r.frameActive;
      end
   end

   wire frameNow   = busS2_r.frameActive;
   wire frameRise  = frameNow && !framePrev_r;
   wire frameStart = (state_r == ST_IDLE) && frameRise;
   wire accept     = frameNow && ((state_r == ST_FRAME) || frameStart);
   wire colNow     = accept && !busS2_r.sharedCollision_n;
   wire colEvent   = colNow && !colPrev_r;
   wire idEvent    = idTogS2_r ^ idTogS3_r;
   wire settleDone = (settleCnt_r == 8'h00);
   wire fifoInReady;

   wire [7:0]  collBase = frameStart ? 8'h00 : collisions_r;
   wire [15:0] nibBase  = frameStart ? 16'h0000 : nibbles_r;
   wire [3:0]  xorBase  = frameStart ? 4'h0 : nibbleXor_r;
   wire [7:0]  collisions_nxt = collBase + 8'(colEvent && (collBase != 8'hFF));
   wire [15:0] nibbles_nxt    = nibBase + 16'(accept && (nibBase != 16'hFFFF));
   wire [3:0]  nibbleXor_nxt  = accept ? (xorBase ^ busS2_r.txNibble) : xorBase;
   wire        symbolErr_nxt  = (frameStart ? 1'b0 : symbolError_r)
                                || (accept && busS2_r.transmitSymbolError);

   rbm_stat_t statIn;
   assign statIn = '{idLocal_r, idValid_r, symbolError_r, falseCarrier_r, mismatchS2_r,
                     collisions_r, nibbles_r, nibbleXor_r};

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:   if (frameRise) state_nxt = ST_FRAME;
         ST_FRAME:  if (!frameNow) state_nxt = ST_SETTLE;
         ST_SETTLE: if (settleDone) state_nxt = ST_COMMIT;
         ST_COMMIT: if (fifoInReady) state_nxt = ST_IDLE;
         default:   state_nxt = ST_IDLE;
      endcase
   end

   // The settle wait lets the mismatch level cross before the record is taken.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r     <= ST_IDLE;
         settleCnt_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == ST_FRAME)
            settleCnt_r <= 8'(SETTLE_CYCLES - 1);
         else if (!settleDone)
            settleCnt_r <= settleCnt_r - 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         symbolError_r  <= 1'b0;
         falseCarrier_r <= 1'b0;
         colPrev_r      <= 1'b0;
         collisions_r   <= 8'h00;
         nibbles_r      <= 16'h0000;
         nibbleXor_r    <= 4'h0;
         frameTog_r     <= 1'b0;
      end
      else
      begin
         symbolError_r <= symbolErr_nxt;
         colPrev_r     <= colNow;
         collisions_r  <= collisions_nxt;
         nibbles_r     <= nibbles_nxt;
         nibbleXor_r   <= nibbleXor_nxt;
         if (frameStart)
         begin
            falseCarrier_r <= busS2_r.busDataValid_n;
            frameTog_r     <= !frameTog_r;
         end
      end
   end

   // A frame that begins before the previous record is queued is lost.
   always_ff @(posedge clk)
   begin
      if (rst)
         overrun_r <= 1'b0;
      else if (frameRise && (state_r != ST_IDLE))
         overrun_r <= 1'b1;
      else if (overrunClear)
         overrun_r <= 1'b0;
   end

   // Identity word is stable in the other domain whenever its toggle changes.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         idTogS1_r    <= 1'b0;
         idTogS2_r    <= 1'b0;
         idTogS3_r    <= 1'b0;
         mismatchS1_r <= 1'b0;
         mismatchS2_r <= 1'b0;
         idLocal_r    <= '0;
         idValid_r    <= 1'b0;
      end
      else
      begin
         idTogS1_r    <= idTog_r;
         idTogS2_r    <= idTogS1_r;
         idTogS3_r    <= idTogS2_r;
         mismatchS1_r <= mismatch_r;
         mismatchS2_r <= mismatchS1_r;
         if (idEvent)
         begin
            idLocal_r <= idMgmt_r;
            idValid_r <= 1'b1;
         end
         else if (frameStart)
            idValid_r <= 1'b0;
      end
   end

   rbm_fifo
      #(
         .WIDTH ($bits(rbm_stat_t)),
         .DEPTH (FIFO_DEPTH)
      )
      u_fifo
      (
         .clk      (clk),
         .rst      (rst),
         .inData   (statIn),
         .inValid  (state_r == ST_COMMIT),
         .inReady  (fifoInReady),
         .outData  (statRecord),
         .outValid (statValid),
         .outReady (statReady)
      );

   assign overrun = overrun_r;

   // Management domain reset follows rst through two flops.
   always_ff @(posedge mgmtClock)
   begin
      mRstS1_r <= rst;
      mRst_r   <= mRstS1_r;
   end

   // Frame starts cross as a toggle, so a clock that stops between frames misses none.
   wire mgmtFrameStart = tgS2_r ^ fmPrev_r;
   wire idCapture      = fmS2_r && !mgmtValid_n && (mgmtFrameStart || !idDone_r);
   wire phaseNow       = mgmtFrameStart ? 1'b0 : nibPhase_r;

   always_ff @(posedge mgmtClock)
   begin
      if (mRst_r)
      begin
         fmS1_r     <= 1'b0;
         fmS2_r     <= 1'b0;
         fmPrev_r   <= 1'b0;
         tgS1_r     <= 1'b0;
         tgS2_r     <= 1'b0;
         nibPhase_r <= 1'b0;
         idDone_r   <= 1'b0;
         idTog_r    <= 1'b0;
         mismatch_r <= 1'b0;
         idMgmt_r   <= '0;
      end
      else
      begin
         fmS1_r   <= busS2_r.frameActive;
         fmS2_r   <= fmS1_r;
         tgS1_r   <= frameTog_r;
         tgS2_r   <= tgS1_r;
         fmPrev_r <= tgS2_r;
         if (mgmtFrameStart)
         begin
            nibPhase_r <= 1'b0;
            idDone_r   <= 1'b0;
         end
         if (idCapture && !phaseNow)
         begin
            idMgmt_r.controllerIndex <= mgmtNibble;
            nibPhase_r               <= 1'b1;
         end
         else if (idCapture)
         begin
            idMgmt_r.portNumber <= mgmtNibble;
            idDone_r            <= 1'b1;
            idTog_r             <= !idTog_r;
         end
         if (fmS2_r && !rateMismatchError_n)
            mismatch_r <= 1'b1;
         else if (mgmtFrameStart)
            mismatch_r <= 1'b0;
      end
   end

   sequence s_frameEnd;
      (state_r == ST_FRAME) && !busS2_r.frameActive;
   endsequence

   sequence s_settleThenCommit;
      (state_r == ST_SETTLE) [*4] ##1 (state_r == ST_COMMIT);
   endsequence

   property p_commitOnce;
      @(posedge clk) disable iff (rst)
      s_frameEnd |=> s_settleThenCommit;
   endproperty
   a_commitOnce: assert property (p_commitOnce)
      else $error("Record not committed after settle wait.");

   property p_nibbleCount;
      @(posedge clk) disable iff (rst)
      (state_r == ST_FRAME) && busS2_r.frameActive && (nibbles_r != 16'hFFFF)
      |=> nibbles_r == $past(nibbles_r) + 16'h0001;
   endproperty
   a_nibbleCount: assert property (p_nibbleCount)
      else $error("Framed nibble not counted.");

   property p_gated;
      @(posedge clk) disable iff (rst)
      !busS2_r.frameActive |=> $stable(nibbles_r) && $stable(symbolError_r)
                               && $stable(collisions_r);
   endproperty
   a_gated: assert property (p_gated)
      else $error("Statistics changed outside a frame.");

   property p_symbolError;
      @(posedge clk) disable iff (rst)
      accept && busS2_r.transmitSymbolError |=> symbolError_r throughout
      (state_r != ST_COMMIT) [*1] ##1 1'b1;
   endproperty
   a_symbolError: assert property (p_symbolError)
      else $error("Transmit error did not mark symbol violation.");

   property p_collision;
      @(posedge clk) disable iff (rst)
      (state_r == ST_FRAME) && busS2_r.frameActive && !busS2_r.sharedCollision_n
      && !colPrev_r && (collisions_r != 8'hFF)
      |=> collisions_r == $past(collisions_r) + 8'h01;
   endproperty
   a_collision: assert property (p_collision)
      else $error("Collision onset not counted.");

   property p_falseCarrier;
      @(posedge clk) disable iff (rst)
      frameStart |=> falseCarrier_r == $past(busS2_r.busDataValid_n);
   endproperty
   a_falseCarrier: assert property (p_falseCarrier)
      else $error("False carrier not taken at frame start.");

   property p_portLatch;
      @(posedge mgmtClock) disable iff (mRst_r)
      idCapture && phaseNow
      |=> (idTog_r != $past(idTog_r)) && (idMgmt_r.portNumber == $past(mgmtNibble));
   endproperty
   a_portLatch: assert property (p_portLatch)
      else $error("Port nibble not latched with toggle.");

   property p_indexLatch;
      @(posedge mgmtClock) disable iff (mRst_r)
      idCapture && !phaseNow
      |=> nibPhase_r && (idMgmt_r.controllerIndex == $past(mgmtNibble));
   endproperty
   a_indexLatch: assert property (p_indexLatch)
      else $error("Controller index not latched.");

   property p_mismatch;
      @(posedge mgmtClock) disable iff (mRst_r)
      fmS2_r && !rateMismatchError_n |=> mismatch_r;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("Rate mismatch not marked.");

   property p_mismatchCross;
      @(posedge clk) disable iff (rst)
      $rose(mismatchS1_r) |=> mismatchS2_r;
   endproperty
   a_mismatchCross: assert property (p_mismatchCross)
      else $error("Mismatch level lost in crossing.");

endmodule

// *** sim/rbm_ctrl_model.sv ***
// Behavioural arbitration winner that drives the management clock and management bus.
`timescale 1ns/1ns
module rbm_ctrl_model
   (
      input  wire logic       go,
      input  wire logic       ident,
      input  wire logic [3:0] idx,
      input  wire logic [3:0] port,
      input  wire logic       mis,
      output logic            mgmtClock,
      output logic      [3:0] mgmtNibble,
      output logic            mgmtValid_n,
      output logic            rateMismatchError_n
   );
   int n;

   // The clock runs while go is high and finishes its current cycle after go falls; idle nibbles flip so stale data never looks valid.
   initial
   begin
      mgmtClock = 1'b0;
      mgmtNibble = 4'h0;
      mgmtValid_n = 1'b1;
      rateMismatchError_n = 1'b1;
      forever
      begin
         @(posedge go);
         n = 0;
         #7;
         while (go)
         begin
            #40 mgmtClock = 1'b1;
            n = n + 1;
            #1;
            mgmtValid_n = !(ident && (n == 6 || n == 7));
            mgmtNibble = (ident && n == 6) ? idx : (ident && n == 7) ? port : ~mgmtNibble;
            rateMismatchError_n = !(mis && n >= 8);
            #39 mgmtClock = 1'b0;
         end
         mgmtValid_n = 1'b1;
         rateMismatchError_n = 1'b1;
      end
   end
endmodule

// *** sim/rbm_frame_monitor_tb.sv ***
// Self-checking bench for the repeater bus frame monitor.
`timescale 1ns/1ns
module rbm_frame_monitor_tb
   import rbm_pkg::*;
   ;
   logic       clk, rst, go, ident, mis, frameActive, transmitSymbolError;
   logic       sharedCollision_n, busDataValid_n, statReady, overrunClear;
   logic [3:0] txNibble, idx, port, mgmtNibble;
   logic       mgmtClock, mgmtValid_n, rateMismatchError_n, statValid, overrun;
   rbm_stat_t  statRecord;
   rbm_stat_t  expQ[$];
   logic [39:0] mskQ[$];
   int         miscompares, checked;

   rbm_frame_monitor i_rbm_frame_monitor (.clk(clk), .rst(rst), .mgmtClock(mgmtClock),
      .txNibble(txNibble), .frameActive(frameActive), .transmitSymbolError(transmitSymbolError),
      .sharedCollision_n(sharedCollision_n), .busDataValid_n(busDataValid_n),
      .mgmtNibble(mgmtNibble), .mgmtValid_n(mgmtValid_n),
      .rateMismatchError_n(rateMismatchError_n), .statReady(statReady), .statValid(statValid),
      .statRecord(statRecord), .overrunClear(overrunClear), .overrun(overrun));

   rbm_ctrl_model i_rbm_ctrl_model (.go(go), .ident(ident), .idx(idx), .port(port), .mis(mis),
      .mgmtClock(mgmtClock), .mgmtNibble(mgmtNibble), .mgmtValid_n(mgmtValid_n),
      .rateMismatchError_n(rateMismatchError_n));

   always #25 clk = ~clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Optional noise outside the frame must leave no trace in the record.
   task automatic drive_frame(input int len, input logic dvN, input int errAt, input int cols,
      input logic idn, input logic [3:0] ix, input logic [3:0] pt, input logic ms,
      input logic nz, input int gap, input logic push);
      rbm_stat_t   e;
      logic [39:0] m;
      e = '0;
      m = idn ? 40'hff_ffff_ffff : 40'h00_ffff_ffff;
      e.source.controllerIndex = ix;
      e.source.portNumber = pt;
      e.sourceValid = idn;
      e.symbolError = (errAt >= 0 && errAt < len);
      e.falseCarrier = dvN;
      e.rateMismatch = ms;
      e.collisions = 8'(cols);
      e.nibbles = 16'(len);
      if (nz)
      begin
         transmitSymbolError = 1'b1;
         sharedCollision_n = 1'b0;
         repeat (2) @(negedge clk);
         transmitSymbolError = 1'b0;
         sharedCollision_n = 1'b1;
         repeat (4) @(negedge clk);
      end
      idx = ix;
      port = pt;
      ident = idn;
      mis = ms;
      go = 1'b1;
      frameActive = 1'b1;
      busDataValid_n = dvN;
      for (int i = 0; i < len; i++)
      begin
         txNibble = i[3:0] ^ 4'h5;
         e.nibbleXor = e.nibbleXor ^ txNibble;
         transmitSymbolError = (i == errAt);
         sharedCollision_n = !((i % 6 == 4 || i % 6 == 5) && i / 6 < cols);
         @(negedge clk);
      end
      frameActive = 1'b0;
      go = 1'b0;
      transmitSymbolError = 1'b0;
      sharedCollision_n = 1'b1;
      busDataValid_n = 1'b1;
      txNibble = 4'hf;
      if (push)
      begin
         expQ.push_back(e);
         mskQ.push_back(m);
      end
      repeat (gap) @(negedge clk);
   endtask

   task automatic collect();
      int w;
      w = 0;
      while (statValid !== 1'b1 && w < 60)
      begin
         @(negedge clk);
         w++;
      end
      check(statValid, 1'b1);
      check(statRecord & mskQ[0], expQ[0] & mskQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
      statReady = 1'b1;
      @(negedge clk);
      statReady = 1'b0;
      @(negedge clk);
   endtask

   task automatic reset_case();
      check({statValid, overrun, statRecord}, 42'h0);
   endtask

   task automatic basic_case();
      drive_frame(20, 1'b0, -1, 2, 1'b1, 4'h5, 4'h9, 1'b0, 1'b1, 12, 1'b1);
      collect();
   endtask

   task automatic error_case();
      drive_frame(24, 1'b1, 7, 1, 1'b1, 4'ha, 4'h3, 1'b1, 1'b1, 12, 1'b1);
      collect();
   endtask

   task automatic anon_case();
      drive_frame(20, 1'b0, -1, 0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b1, 12, 1'b1);
      collect();
   endtask

   task automatic fill_case();
      for (int k = 0; k < 10; k++)
         drive_frame(4 + k, 1'b0, -1, 0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 12, 1'b1);
      check(statValid, 1'b1);
      repeat (10) collect();
      check(overrun, 1'b0);
   endtask

   task automatic overrun_case();
      drive_frame(6, 1'b0, -1, 0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 2, 1'b1);
      drive_frame(2, 1'b0, -1, 0, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, 14, 1'b0);
      collect();
      check(overrun, 1'b1);
      repeat (20) @(negedge clk);
      check(statValid, 1'b0);
      overrunClear = 1'b1;
      @(negedge clk);
      overrunClear = 1'b0;
      @(negedge clk);
      check(overrun, 1'b0);
   endtask

   initial
   begin
      #(4000 * 50);
      miscompares++;
      wrap_up();
   end

   // The management clock is kept running across reset so its domain leaves reset too.
   initial
   begin
      {clk, go, ident, mis, frameActive, transmitSymbolError, statReady, overrunClear} = '0;
      {sharedCollision_n, busDataValid_n, rst} = 3'b111;
      {txNibble, idx, port} = 12'h0;
      miscompares = 0;
      checked = 0;
      @(negedge clk);
      go = 1'b1;
      repeat (3) @(negedge clk);
      reset_case();
      rst = 1'b0;
      repeat (4) @(negedge clk);
      go = 1'b0;
      repeat (4) @(negedge clk);
      basic_case();
      error_case();
      anon_case();
      fill_case();
      overrun_case();
      wrap_up();
   end
endmodule
